// File: design/nvf_front_end.sv
// spi slave command front end of a serial nonvolatile sram
`timescale 1ns/1ps
`include "nvf_defs.svh"
// Operation
// - recall opcode starts a recall; array access blocked until the recall time ends
// - after store-disable, no automatic store at power fail
// - store-enable switches automatic power-down store back on
// - store-enable setting is volatile, lost over a power cycle
// - automatic power-down store is enabled after reset
// - power-up recall always runs after reset, nothing suppresses it
// - input bits sampled on rising clock edges from first edge after select
// - first byte after select is the opcode; address and data follow
// - one opcode per select; a new instruction needs a new select fall
// - deselected: serial input ignored, serial output tristated
// - serial output changes on falling clock edges
// - all bytes shifted most significant bit first
// - three address bytes; only the low 17 bits are kept
// - invalid opcode: ignore rest of select cycle, output stays tristated
// - clock level at select fall picks mode 0 or mode 3
// - in mode 3 the first rising edge counts only after clock went low
// - only the master starts transfers; device never drives unselected
// - recall opcode is 0x60
// - power-down store enable opcode is 0x59
// - power-down store disable opcode is 0x19
// - busy flag is 1 for the whole store or recall cycle
module nvf_front_end
    import nvf_pkg::*;
#(
    parameter int RECALL_CYC = `NVF_RECALL_CYC
) (
    input  wire logic                   core_clk_i,
    input  wire logic                   nrst_i,
    input  wire logic                   spi_cs_n_i,
    input  wire logic                   spi_sck_i,
    input  wire logic                   spi_mosi_i,
    output logic                        spi_miso_o,
    output logic                        spi_miso_oe_o,
    input  wire logic                   power_fail_i,
    input  wire logic                   store_busy_i,
    input  wire logic [7:0]             tx_byte_i,
    input  wire logic                   rx_ready_i,
    output logic                        rx_valid_o,
    output logic [7:0]                  rx_data_o,
    output logic [7:0]                  opcode_o,
    output logic                        opcode_stb_o,
    output logic [`NVF_ADDR_W-1:0]      addr_o,
    output logic                        addr_stb_o,
    output logic                        rd_next_o,
    output logic                        recall_start_o,
    output logic                        pdstore_req_o,
    output logic                        pdstore_en_o,
    output logic                        busy_o,
    output logic                        array_block_o,
    output logic                        overrun_o
);
    localparam int RMAX = (1 << `NVF_RCNT_W) - 1;

    if (RECALL_CYC < 1 || RECALL_CYC > RMAX) begin : g_bad_recall
        $error("RECALL_CYC out of range");
    end

    function automatic nvf_kind_t op_kind(input logic [7:0] op);
        case (op)
            `NVF_OP_READ,
            `NVF_OP_WRITE:  op_kind = NVF_K_MEM;
            `NVF_OP_RDSR:   op_kind = NVF_K_RDSR;
            `NVF_OP_RECALL: op_kind = NVF_K_RECALL;
            `NVF_OP_PDS_EN:  op_kind = NVF_K_ASEN;
            `NVF_OP_PDS_DIS: op_kind = NVF_K_ASDIS;
            `NVF_OP_WREN,
            `NVF_OP_WRDI,
            `NVF_OP_WRSR,
            `NVF_OP_STORE:  op_kind = NVF_K_OTHER;
            default:        op_kind = NVF_K_BAD;
        endcase
    endfunction : op_kind

    nvf_fe_state_t st_reg;
    nvf_fe_state_t st_next;
    logic          cs_fall;
    logic          sck_rise;
    logic          sck_fall;
    logic          pf_rise;
    logic          sel;
    logic          rx_bit;
    logic          byte_done;
    logic [7:0]    byte_in;

    nvf_stream_if #(.W(8)) in_s ();
    nvf_stream_if #(.W(8)) out_s ();

    nvf_buf2 #(.W(8)) u_nvf_buf2 (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .in_s       (in_s),
        .out_s      (out_s)
    );

    assign in_s.valid  = st_reg.push;
    assign in_s.data   = st_reg.pdata;
    assign out_s.ready = rx_ready_i;

    // edges seen only through the second sync stage
    assign sel      = !st_reg.cs_sy[1];
    assign cs_fall  = st_reg.cs_d && !st_reg.cs_sy[1];
    assign sck_rise = st_reg.sck_sy[1] && !st_reg.sck_d;
    assign sck_fall = !st_reg.sck_sy[1] && st_reg.sck_d;
    assign pf_rise  = st_reg.pf_sy[1] && !st_reg.pf_d;
    assign byte_in  = {st_reg.shin[6:0], st_reg.mosi_sy[1]};

    always_comb begin
        st_next = st_reg;
        rx_bit  = 1'b0;
        byte_done = 1'b0;
        st_next.cs_sy   = {st_reg.cs_sy[0], spi_cs_n_i};
        st_next.sck_sy  = {st_reg.sck_sy[0], spi_sck_i};
        st_next.mosi_sy = {st_reg.mosi_sy[0], spi_mosi_i};
        st_next.pf_sy   = {st_reg.pf_sy[0], power_fail_i};
        st_next.cs_d    = st_reg.cs_sy[1];
        st_next.sck_d   = st_reg.sck_sy[1];
        st_next.pf_d    = st_reg.pf_sy[1];
        st_next.opc_stb  = 1'b0;
        st_next.addr_stb = 1'b0;
        st_next.rd_next  = 1'b0;
        st_next.rec_stb  = 1'b0;
        st_next.push     = 1'b0;
        st_next.asreq    = pf_rise && st_reg.asen;
        if (st_reg.rcnt != '0) begin
            st_next.rcnt = st_reg.rcnt - `NVF_RCNT_W'(1);
        end
        if (!sel) begin
            st_next.state   = NVF_IDLE;
            st_next.miso_oe = 1'b0;
        end else if (cs_fall) begin
            st_next.state   = NVF_OPC;
            st_next.mode3   = st_reg.sck_sy[1];
            st_next.armed   = !st_reg.sck_sy[1];
            st_next.bitcnt  = 3'h0;
            st_next.txcnt   = 3'h0;
            st_next.bytecnt = 2'h0;
            st_next.ovr     = 1'b0;
        end else begin
            if (sck_fall) begin
                st_next.armed = 1'b1;
            end
            rx_bit = sck_rise && st_reg.armed;
            if (rx_bit) begin
                st_next.shin   = byte_in;
                st_next.bitcnt = st_reg.bitcnt + 3'h1;
                byte_done      = st_reg.bitcnt == 3'h7;
            end
            case (st_reg.state)
                NVF_OPC: begin
                    if (byte_done) begin
                        st_next.opc     = byte_in;
                        st_next.opc_stb = 1'b1;
                        case (op_kind(byte_in))
                            NVF_K_MEM: begin
                                // no array access while a recall or store runs
                                st_next.state = st_reg.busy ? NVF_DROP : NVF_ADDR;
                            end
                            NVF_K_RDSR: st_next.state = NVF_RDATA;
                            NVF_K_RECALL: begin
                                st_next.rcnt    = `NVF_RCNT_W'(RECALL_CYC);
                                st_next.rec_stb = 1'b1;
                                st_next.state   = NVF_DROP;
                            end
                            NVF_K_ASEN: begin
                                st_next.asen  = 1'b1;
                                st_next.state = NVF_DROP;
                            end
                            NVF_K_ASDIS: begin
                                st_next.asen  = 1'b0;
                                st_next.state = NVF_DROP;
                            end
                            NVF_K_OTHER: st_next.state = NVF_WDATA;
                            default:     st_next.state = NVF_DROP;
                        endcase
                    end
                end
                NVF_ADDR: begin
                    if (rx_bit) begin
                        // upper seven of the 24 bits fall off the top
                        st_next.addr = {st_reg.addr[`NVF_ADDR_W-2:0], st_reg.mosi_sy[1]};
                    end
                    if (byte_done) begin
                        st_next.bytecnt = st_reg.bytecnt + 2'h1;
                        if (st_reg.bytecnt == `NVF_ADDR_BYTES) begin
                            st_next.addr_stb = 1'b1;
                            st_next.state = (st_reg.opc == `NVF_OP_READ) ? NVF_RDATA : NVF_WDATA;
                        end
                    end
                end
                NVF_WDATA: begin
                    if (byte_done) begin
                        // spi cannot be stalled; a full buffer drops the byte
                        st_next.push  = in_s.ready;
                        st_next.pdata = byte_in;
                        st_next.ovr   = st_reg.ovr || !in_s.ready;
                    end
                end
                NVF_RDATA: begin
                    if (sck_fall) begin
                        st_next.miso_oe = 1'b1;
                        st_next.txcnt   = st_reg.txcnt + 3'h1;
                        if (st_reg.txcnt == 3'h0) begin
                            st_next.miso    = tx_byte_i[7];
                            st_next.shout   = {tx_byte_i[6:0], 1'b0};
                            st_next.rd_next = 1'b1;
                        end else begin
                            st_next.miso  = st_reg.shout[7];
                            st_next.shout = {st_reg.shout[6:0], 1'b0};
                        end
                    end
                end
                NVF_DROP: st_next.miso_oe = 1'b0;
                NVF_IDLE: st_next.miso_oe = 1'b0;
                default:  st_next.state = NVF_IDLE;
            endcase
        end
        st_next.blk  = st_next.rcnt != '0;
        st_next.busy = st_next.blk || store_busy_i;
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            st_reg        <= '0;
            st_reg.state  <= NVF_IDLE;
            st_reg.cs_sy  <= 2'h3;
            st_reg.cs_d   <= 1'b1;
            st_reg.asen   <= `NVF_ASEN_RST;
            st_reg.rcnt   <= `NVF_RCNT_W'(RECALL_CYC);
            st_reg.blk    <= 1'b1;
            st_reg.busy   <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign spi_miso_o      = st_reg.miso;
    assign spi_miso_oe_o   = st_reg.miso_oe;
    assign rx_valid_o      = out_s.valid;
    assign rx_data_o       = out_s.data;
    assign opcode_o        = st_reg.opc;
    assign opcode_stb_o    = st_reg.opc_stb;
    assign addr_o          = st_reg.addr;
    assign addr_stb_o      = st_reg.addr_stb;
    assign rd_next_o       = st_reg.rd_next;
    assign recall_start_o  = st_reg.rec_stb;
    assign pdstore_req_o   = st_reg.asreq;
    assign pdstore_en_o    = st_reg.asen;
    assign busy_o          = st_reg.busy;
    assign array_block_o   = st_reg.blk;
    assign overrun_o       = st_reg.ovr;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i);

    sequence s_recall_cmd;
        opcode_stb_o && opcode_o == `NVF_OP_RECALL;
    endsequence

    sequence s_blocked_two;
        array_block_o && busy_o ##1 array_block_o;
    endsequence

    property p_recall_blocks;
        s_recall_cmd |-> recall_start_o ##0 s_blocked_two;
    endproperty
    a_recall_blocks: assert property (p_recall_blocks)
        else $error("recall did not block the array");

    property p_no_store_when_off;
        (pf_rise && !st_reg.asen) |=> !pdstore_req_o;
    endproperty
    a_no_store_when_off: assert property (p_no_store_when_off)
        else $error("power-down store requested while disabled");

    property p_enable_cmd;
        (opcode_stb_o && opcode_o == `NVF_OP_PDS_EN) |-> pdstore_en_o;
    endproperty
    a_enable_cmd: assert property (p_enable_cmd)
        else $error("store enable opcode left store disabled");

    property p_reset_state;
        $past(!nrst_i) |-> pdstore_en_o && array_block_o && busy_o;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("reset did not start recall with store enabled");

    property p_desel_tristate;
        !sel |=> !spi_miso_oe_o;
    endproperty
    a_desel_tristate: assert property (p_desel_tristate)
        else $error("output driven while deselected");

    property p_out_on_fall;
        $changed(spi_miso_o) |-> $past(sck_fall);
    endproperty
    a_out_on_fall: assert property (p_out_on_fall)
        else $error("serial output changed away from a falling edge");

    property p_invalid_quiet;
        st_reg.state == NVF_DROP |=> !spi_miso_oe_o;
    endproperty
    a_invalid_quiet: assert property (p_invalid_quiet)
        else $error("output driven after a discarded opcode");

    property p_one_opcode;
        opcode_stb_o |-> $past(st_reg.state) == NVF_OPC && st_reg.state != NVF_OPC;
    endproperty
    a_one_opcode: assert property (p_one_opcode)
        else $error("opcode taken outside the opcode byte");

    property p_mode_latch;
        cs_fall |=> st_reg.mode3 == $past(st_reg.sck_sy[1]);
    endproperty
    a_mode_latch: assert property (p_mode_latch)
        else $error("mode not taken from clock level at select");

    property p_busy_flag;
        array_block_o |-> busy_o;
    endproperty
    a_busy_flag: assert property (p_busy_flag)
        else $error("busy flag low during recall");

    property p_busy_drops_access;
        (opcode_stb_o && $past(busy_o) && op_kind(opcode_o) == NVF_K_MEM)
            |-> st_reg.state == NVF_DROP;
    endproperty
    a_busy_drops_access: assert property (p_busy_drops_access)
        else $error("array access opened while busy");

    property p_drive_on_fall;
        $rose(spi_miso_oe_o) |-> $past(sck_fall);
    endproperty
    a_drive_on_fall: assert property (p_drive_on_fall)
        else $error("output enabled without a master clock fall");

endmodule : nvf_front_end

// File: design/nvf_defs.svh
// opcode values, reset values and timing counts of the command front end
`ifndef NVF_DEFS_SVH
`define NVF_DEFS_SVH

`define NVF_OP_WREN    8'h06
`define NVF_OP_WRDI    8'h04
`define NVF_OP_RDSR    8'h05
`define NVF_OP_WRSR    8'h01
`define NVF_OP_READ    8'h03
`define NVF_OP_WRITE   8'h02
`define NVF_OP_STORE   8'h3C
`define NVF_OP_RECALL  8'h60
`define NVF_OP_PDS_EN  8'h59
`define NVF_OP_PDS_DIS 8'h19

`define NVF_ADDR_W     17
`define NVF_ADDR_BYTES 2'h2
`define NVF_ASEN_RST   1'b1
`define NVF_RCNT_W     16

`define NVF_CLK_NS     100
`define NVF_RECALL_NS  100000
`define NVF_RECALL_CYC ((`NVF_RECALL_NS + `NVF_CLK_NS - 1) / `NVF_CLK_NS)

`endif

// File: design/nvf_pkg.sv
// types of the command front end
`include "nvf_defs.svh"
package nvf_pkg;

    typedef enum logic [5:0] {
        NVF_IDLE  = 6'b000001,
        NVF_OPC   = 6'b000010,
        NVF_ADDR  = 6'b000100,
        NVF_WDATA = 6'b001000,
        NVF_RDATA = 6'b010000,
        NVF_DROP  = 6'b100000
    } nvf_state_t;

    typedef enum logic [2:0] {
        NVF_K_BAD,
        NVF_K_MEM,
        NVF_K_RDSR,
        NVF_K_RECALL,
        NVF_K_ASEN,
        NVF_K_ASDIS,
        NVF_K_OTHER
    } nvf_kind_t;

    typedef struct packed {
        nvf_state_t                state;
        logic [1:0]                cs_sy;
        logic [1:0]                sck_sy;
        logic [1:0]                mosi_sy;
        logic [1:0]                pf_sy;
        logic                      cs_d;
        logic                      sck_d;
        logic                      pf_d;
        logic                      mode3;
        logic                      armed;
        logic [2:0]                bitcnt;
        logic [2:0]                txcnt;
        logic [1:0]                bytecnt;
        logic [7:0]                shin;
        logic [7:0]                shout;
        logic [`NVF_ADDR_W-1:0]    addr;
        logic [`NVF_RCNT_W-1:0]    rcnt;
        logic                      asen;
        logic                      miso;
        logic                      miso_oe;
        logic [7:0]                opc;
        logic                      opc_stb;
        logic                      addr_stb;
        logic                      rd_next;
        logic                      rec_stb;
        logic                      asreq;
        logic                      busy;
        logic                      blk;
        logic                      ovr;
        logic                      push;
        logic [7:0]                pdata;
    } nvf_fe_state_t;

    typedef struct packed {
        logic [7:0] d0;
        logic [7:0] d1;
        logic       v0;
        logic       v1;
    } nvf_buf_state_t;

endpackage : nvf_pkg

// File: design/nvf_stream_if.sv
// byte stream between the front end and its buffer
`timescale 1ns/1ps
interface nvf_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : nvf_stream_if

// File: design/nvf_buf2.sv
// two-entry buffer; output taken straight from the head register
`timescale 1ns/1ps
module nvf_buf2
    import nvf_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic   core_clk_i,
    input  wire logic   nrst_i,
    nvf_stream_if.snk   in_s,
    nvf_stream_if.src   out_s
);
    nvf_buf_state_t st_reg;
    nvf_buf_state_t st_next;
    logic           pop;
    logic           psh;

    if (W != 8) begin : g_bad_w
        $error("nvf_buf2 carries bytes only");
    end

    assign pop         = st_reg.v0 && out_s.ready;
    assign psh         = in_s.valid && !st_reg.v1;
    assign in_s.ready  = !st_reg.v1;
    assign out_s.valid = st_reg.v0;
    assign out_s.data  = st_reg.d0;

    always_comb begin
        st_next = st_reg;
        if (pop) begin
            st_next.d0 = st_reg.d1;
            st_next.v0 = st_reg.v1;
            st_next.v1 = 1'b0;
        end
        if (psh) begin
            if (!st_next.v0) begin
                st_next.d0 = in_s.data;
                st_next.v0 = 1'b1;
            end else begin
                st_next.d1 = in_s.data;
                st_next.v1 = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule : nvf_buf2

// File: tb/nvf_spi_master.sv
// spi bus master model driving the command front end
`timescale 1ns/1ps
module nvf_spi_master (
    input  wire logic core_clk_i,
    output logic      cs_n_o,
    output logic      sck_o,
    output logic      mosi_o,
    input  wire logic miso_i,
    input  wire logic miso_oe_i
);
    logic alt = 1'b0;
    logic m3  = 1'b0;
    wire  line = miso_oe_i ? miso_i : ~alt; // released line shows no stale bit
    initial begin
        cs_n_o = 1'b1;
        sck_o  = 1'b0;
        mosi_o = 1'b0;
    end
    always @(posedge core_clk_i) alt <= ~alt;
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : wt
    // idle level set before select; half period 4 core cycles, 800 ns sck
    task automatic start(input logic mode3);
        m3 = mode3;
        wt(1);
        sck_o <= mode3;
        wt(4);
        cs_n_o <= 1'b0;
        wt(4);
    endtask : start
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            if (m3) sck_o <= 1'b0;
            mosi_o <= tx[i];
            wt(4);
            sck_o <= 1'b1;
            wt(4);
            rx[i] = line;
            if (!m3) sck_o <= 1'b0;
        end
    endtask : xfer
    task automatic stop();
        wt(4);
        cs_n_o <= 1'b1;
        mosi_o <= ~mosi_o;
        wt(8);
    endtask : stop
    // clock and data wiggle while deselected
    task automatic noise();
        for (int i = 0; i < 16; i++) begin
            wt(4);
            sck_o  <= ~sck_o;
            mosi_o <= ~mosi_o;
        end
        sck_o <= 1'b0;
        wt(4);
    endtask : noise
endmodule : nvf_spi_master

// File: tb/tb_nvf_front_end.sv
// self-checking bench of the command front end
`timescale 1ns/1ps
module tb_nvf_front_end;
    import nvf_pkg::*;
    localparam int RCYC = 400; // long enough to cover a whole read frame
    logic        core_clk_i = 1'b0;
    logic        nrst_i     = 1'b0;
    logic        pfail      = 1'b0;
    logic        sbusy      = 1'b0;
    logic        rx_ready   = 1'b0;
    logic [7:0]  tx_byte    = 8'hA5;
    logic        cs_n, sck, mosi, miso, miso_oe, rx_valid, opc_stb, addr_stb, rd_next;
    logic        rec, asreq, as_en, busy, blk, ovr;
    logic [7:0]  rx_data, opc, r;
    logic [16:0] addr;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          n_opc, n_addr, n_rec, n_asr, n_oe, n_rd, n_blk;

    always #50 core_clk_i = ~core_clk_i;

    nvf_spi_master u_nvf_spi_master (.core_clk_i(core_clk_i), .cs_n_o(cs_n), .sck_o(sck),
        .mosi_o(mosi), .miso_i(miso), .miso_oe_i(miso_oe));

    nvf_front_end #(.RECALL_CYC(RCYC)) u_nvf_front_end (.core_clk_i(core_clk_i),
        .nrst_i(nrst_i), .spi_cs_n_i(cs_n), .spi_sck_i(sck), .spi_mosi_i(mosi),
        .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .power_fail_i(pfail),
        .store_busy_i(sbusy), .tx_byte_i(tx_byte), .rx_ready_i(rx_ready),
        .rx_valid_o(rx_valid), .rx_data_o(rx_data), .opcode_o(opc), .opcode_stb_o(opc_stb),
        .addr_o(addr), .addr_stb_o(addr_stb), .rd_next_o(rd_next), .recall_start_o(rec),
        .pdstore_req_o(asreq), .pdstore_en_o(as_en), .busy_o(busy),
        .array_block_o(blk), .overrun_o(ovr));

    always @(posedge core_clk_i) begin
        n_opc  += (opc_stb === 1'b1);
        n_addr += (addr_stb === 1'b1);
        n_rec  += (rec === 1'b1);
        n_asr  += (asreq === 1'b1);
        n_oe   += (miso_oe === 1'b1);
        n_rd   += (rd_next === 1'b1);
        n_blk  += (blk === 1'b1);
    end

    task automatic clr();
        @(negedge core_clk_i);
        {n_opc, n_addr, n_rec, n_asr, n_oe, n_rd, n_blk} = '0;
    endtask : clr
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : cyc
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check
    task automatic cmd(input logic m3, input logic [7:0] op);
        u_nvf_spi_master.start(m3);
        u_nvf_spi_master.xfer(op, r);
        u_nvf_spi_master.stop();
        #1;
    endtask : cmd
    task automatic pf();
        @(posedge core_clk_i) pfail <= 1'b1;
        cyc(6);
        @(posedge core_clk_i) pfail <= 1'b0;
        cyc(6);
    endtask : pf
    task automatic report_and_stop();
        $display("fail_count=%0d samples_checked=%0d", fail_count, samples_checked);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #1_000_000;
        fail_count++;
        report_and_stop();
    end

    initial begin
        repeat (6) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        cyc(1);
        check(as_en, 1);
        check(blk, 1);
        check(miso_oe, 0);
        cyc(RCYC + 5);
        check(blk, 0);
        clr();
        u_nvf_spi_master.noise();
        check(n_opc + n_oe, 0);
        // recall, then a read that arrives while the array is still blocked
        clr();
        cmd(1'b0, 8'h60);
        check(opc, 8'h60);
        check(n_rec, 1);
        check(n_opc, 1);
        check({blk, busy}, 2'b11);
        u_nvf_spi_master.start(1'b0);
        u_nvf_spi_master.xfer(8'h03, r);
        for (int i = 0; i < 4; i++) u_nvf_spi_master.xfer(8'h00, r);
        u_nvf_spi_master.stop();
        check(n_addr, 0);
        check(n_oe, 0);
        cyc(RCYC);
        check(n_blk, RCYC);
        @(posedge core_clk_i) sbusy <= 1'b1;
        cyc(3);
        check(busy, 1);
        @(posedge core_clk_i) sbusy <= 1'b0;
        cyc(3);
        check(busy, 0);
        // store disable in mode 0, enable in mode 3
        clr();
        cmd(1'b0, 8'h19);
        check(as_en, 0);
        pf();
        check(n_asr, 0);
        cmd(1'b1, 8'h59);
        check(opc, 8'h59);
        check(as_en, 1);
        pf();
        check(n_asr, 1);
        cmd(1'b0, 8'h19);
        @(posedge core_clk_i) nrst_i <= 1'b0;
        cyc(2);
        @(posedge core_clk_i) nrst_i <= 1'b1;
        cyc(1);
        check(as_en, 1);
        cyc(RCYC + 5);
        // read in mode 3, upper address bits zero except bit 16
        clr();
        u_nvf_spi_master.start(1'b1);
        u_nvf_spi_master.xfer(8'h03, r);
        u_nvf_spi_master.xfer(8'h01, r);
        u_nvf_spi_master.xfer(8'h5A, r);
        u_nvf_spi_master.xfer(8'hC3, r);
        u_nvf_spi_master.xfer(8'h00, r);
        u_nvf_spi_master.stop();
        check(addr, 17'h15AC3);
        check(n_addr, 1);
        check(r, 8'hA5);
        check(n_rd != 0, 1);
        // status read in mode 0: first bit out on the fall after the opcode
        u_nvf_spi_master.start(1'b0);
        u_nvf_spi_master.xfer(8'h05, r);
        u_nvf_spi_master.xfer(8'h00, r);
        u_nvf_spi_master.stop();
        check(r, 8'hA5);
        // unknown opcode, then bytes that must be ignored
        clr();
        u_nvf_spi_master.start(1'b0);
        u_nvf_spi_master.xfer(8'h1E, r);
        u_nvf_spi_master.xfer(8'h03, r);
        u_nvf_spi_master.xfer(8'h06, r);
        u_nvf_spi_master.stop();
        check(n_oe + n_addr, 0);
        check(rx_valid, 0);
        // write while idle: address kept, one data byte streamed
        clr();
        u_nvf_spi_master.start(1'b0);
        u_nvf_spi_master.xfer(8'h02, r);
        u_nvf_spi_master.xfer(8'h00, r);
        u_nvf_spi_master.xfer(8'h12, r);
        u_nvf_spi_master.xfer(8'h34, r);
        u_nvf_spi_master.xfer(8'h77, r);
        u_nvf_spi_master.stop();
        check(addr, 17'h01234);
        check(n_addr, 1);
        check({rx_valid, rx_data}, {1'b1, 8'h77});
        @(posedge core_clk_i) rx_ready <= 1'b1;
        @(posedge core_clk_i) rx_ready <= 1'b0;
        // three data bytes into a two-entry buffer with the receiver stalled
        u_nvf_spi_master.start(1'b0);
        u_nvf_spi_master.xfer(8'h06, r);
        u_nvf_spi_master.xfer(8'h11, r);
        u_nvf_spi_master.xfer(8'h22, r);
        u_nvf_spi_master.xfer(8'h33, r);
        u_nvf_spi_master.stop();
        cyc(1);
        check({rx_valid, ovr, rx_data}, {2'b11, 8'h11});
        @(posedge core_clk_i) rx_ready <= 1'b1;
        @(posedge core_clk_i) rx_ready <= 1'b0;
        #1;
        check({rx_valid, rx_data}, {1'b1, 8'h22});
        @(posedge core_clk_i) rx_ready <= 1'b1;
        @(posedge core_clk_i) rx_ready <= 1'b0;
        #1;
        check(rx_valid, 0);
        report_and_stop();
    end
endmodule : tb_nvf_front_end
